// *** sof_monitor_map.vh ***
/*
 Register offsets, field positions, reset values and timing counts for the
 frame / SOF monitor of both serial engines. Included by the design files.
*/
`ifndef SOF_MONITOR_MAP_VH
`define SOF_MONITOR_MAP_VH
`define DEV1_STATUS_OFS       16'hc090
`define DEV1_FRAME_OFS        16'hc092
`define DEV1_COUNT_OFS        16'hc094
`define DEV2_STATUS_OFS       16'hc0b0
`define DEV2_FRAME_OFS        16'hc0b2
`define DEV2_COUNT_OFS        16'hc0b4
`define FRAME_TO_FLAG_BIT     15
`define FRAME_TO_CNT_HI       14
`define FRAME_TO_CNT_LO       12
`define FRAME_NUM_HI          10
`define COUNT_HI              13
`define FRAME_RESET           16'h0000
`define COUNT_RESET           14'h2ee0
`define TO_CNT_MAX            3'h7
`define MCLK_HZ               26'h17d7840
`define TICK_HZ               26'h0b71b00
`define TICK_ACC_W            26
`endif

// *** sie_sof_channel.v ***
/*
 One serial engine's status flags, frame capture and SOF/EOP watchdog.
 Assumes all event inputs are one-cycle pulses synchronous to mclk and a
 shared 12 MHz tick enable from the parent.
*/
`timescale 1ns/1ps
`include "sof_monitor_map.vh"
module sie_sof_channel #(
  parameter EP_NUM = 8
) (
  input  wire              mclk,
  input  wire              rst_b,
  input  wire              tick_12m,
  input  wire [EP_NUM-1:0] ep_done,
  input  wire [EP_NUM-1:0] ep_nak,
  input  wire [EP_NUM-1:0] nak_irq_en,
  input  wire              full_speed,
  input  wire              sof_rx,
  input  wire [10:0]       sof_frame,
  input  wire              eop_rx,
  input  wire              to_irq_en,
  input  wire              status_wr,
  input  wire              count_wr,
  input  wire [15:0]       wr_data,
  output wire [15:0]       status_val,
  output wire [15:0]       frame_val,
  output wire [15:0]       count_val,
  output reg               timeout_evt
);
  reg  [EP_NUM-1:0] ep_flag_reg;
  reg  [EP_NUM-1:0] ep_flag_next;
  reg  [10:0]       frame_reg;
  reg               to_flag_reg;
  reg  [2:0]        to_cnt_reg;
  reg  [13:0]       reload_reg;
  reg  [13:0]       down_reg;
  wire              frame_seen;
  wire              expire;
  wire [EP_NUM-1:0] ep_set;

  assign frame_seen = sof_rx | eop_rx;
  assign expire     = tick_12m && (down_reg == 14'h0000) && !frame_seen;
  assign ep_set     = ep_done | (ep_nak & nak_irq_en);

  always @* begin
    ep_flag_next = ep_flag_reg;
    if (status_wr)
      ep_flag_next = ep_flag_next & ~wr_data[EP_NUM-1:0];
    ep_flag_next = ep_flag_next | ep_set;
  end

  always @(posedge mclk) begin
    if (!rst_b) begin
      ep_flag_reg <= {EP_NUM{1'b0}};
      frame_reg   <= 11'h000;
      to_flag_reg <= 1'b0;
      to_cnt_reg  <= 3'h0;
      reload_reg  <= `COUNT_RESET;
      down_reg    <= `COUNT_RESET;
      timeout_evt <= 1'b0;
    end else begin
      ep_flag_reg <= ep_flag_next;
      timeout_evt <= expire;
      if (sof_rx && full_speed)
        frame_reg <= sof_frame;
      if (count_wr)
        reload_reg <= wr_data[`COUNT_HI:0];
      if (frame_seen)
        down_reg <= count_wr ? wr_data[`COUNT_HI:0] : reload_reg;
      else if (count_wr)
        down_reg <= wr_data[`COUNT_HI:0];
      else if (expire)
        down_reg <= reload_reg;
      else if (tick_12m)
        down_reg <= down_reg - 14'h0001;
      if (frame_seen)
        to_flag_reg <= 1'b0;
      else if (expire)
        to_flag_reg <= 1'b1;
      if (to_irq_en) begin
        if (frame_seen)
          to_cnt_reg <= 3'h0;
        else if (expire && to_cnt_reg != `TO_CNT_MAX)
          to_cnt_reg <= to_cnt_reg + 3'h1;
      end
    end
  end

  assign status_val = {{(16-EP_NUM){1'b0}}, ep_flag_reg};
  assign frame_val  = {to_flag_reg, to_cnt_reg, 1'b0, frame_reg};
  assign count_val  = {2'b00, down_reg};
endmodule // sie_sof_channel

// *** usb_device_frame_sof_monitor.v ***
/*
 Peripheral-mode status, frame number and SOF/EOP timeout logic for two
 serial engines, with a 16-bit register port at the documented offsets.
 Assumes event inputs are one-cycle pulses synchronous to mclk.
*/
`timescale 1ns/1ps
`include "sof_monitor_map.vh"
module usb_device_frame_sof_monitor #(
  parameter EP_NUM = 8
) (
  input  wire              mclk,
  input  wire              rst_b,
  input  wire [15:0]       reg_addr,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [15:0]       reg_wdata,
  output reg  [15:0]       reg_rdata,
  input  wire [EP_NUM-1:0] d1_ep_done,
  input  wire [EP_NUM-1:0] d1_ep_nak,
  input  wire [EP_NUM-1:0] d1_nak_irq_en,
  input  wire              d1_full_speed,
  input  wire              d1_sof_rx,
  input  wire [10:0]       d1_sof_frame,
  input  wire              d1_eop_rx,
  input  wire              d1_to_irq_en,
  output wire              d1_timeout,
  input  wire [EP_NUM-1:0] d2_ep_done,
  input  wire [EP_NUM-1:0] d2_ep_nak,
  input  wire [EP_NUM-1:0] d2_nak_irq_en,
  input  wire              d2_full_speed,
  input  wire              d2_sof_rx,
  input  wire [10:0]       d2_sof_frame,
  input  wire              d2_eop_rx,
  input  wire              d2_to_irq_en,
  output wire              d2_timeout
);
  reg  [`TICK_ACC_W-1:0] acc_reg;
  reg  [`TICK_ACC_W-1:0] acc_next;
  reg                    tick_12m;
  wire [15:0]            d1_status;
  wire [15:0]            d1_frame;
  wire [15:0]            d1_count;
  wire [15:0]            d2_status;
  wire [15:0]            d2_frame;
  wire [15:0]            d2_count;
  wire                   d1_status_wr;
  wire                   d1_count_wr;
  wire                   d2_status_wr;
  wire                   d2_count_wr;

  // Offset match shared by all write strobes
  function addr_hit;
    input [15:0] addr;
    input [15:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  assign d1_status_wr = reg_wr && addr_hit(reg_addr, `DEV1_STATUS_OFS);
  assign d1_count_wr  = reg_wr && addr_hit(reg_addr, `DEV1_COUNT_OFS);
  assign d2_status_wr = reg_wr && addr_hit(reg_addr, `DEV2_STATUS_OFS);
  assign d2_count_wr  = reg_wr && addr_hit(reg_addr, `DEV2_COUNT_OFS);

  // Fractional divider: 12 of every 25 mclk cycles carry a tick
  always @* begin
    acc_next = acc_reg + `TICK_HZ;
    tick_12m = 1'b0;
    if (acc_next >= `MCLK_HZ) begin
      acc_next = acc_next - `MCLK_HZ;
      tick_12m = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (!rst_b)
      acc_reg <= {`TICK_ACC_W{1'b0}};
    else
      acc_reg <= acc_next;
  end

  sie_sof_channel #(.EP_NUM(EP_NUM)) dev1 (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .tick_12m    (tick_12m),
    .ep_done     (d1_ep_done),
    .ep_nak      (d1_ep_nak),
    .nak_irq_en  (d1_nak_irq_en),
    .full_speed  (d1_full_speed),
    .sof_rx      (d1_sof_rx),
    .sof_frame   (d1_sof_frame),
    .eop_rx      (d1_eop_rx),
    .to_irq_en   (d1_to_irq_en),
    .status_wr   (d1_status_wr),
    .count_wr    (d1_count_wr),
    .wr_data     (reg_wdata),
    .status_val  (d1_status),
    .frame_val   (d1_frame),
    .count_val   (d1_count),
    .timeout_evt (d1_timeout)
  );

  sie_sof_channel #(.EP_NUM(EP_NUM)) dev2 (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .tick_12m    (tick_12m),
    .ep_done     (d2_ep_done),
    .ep_nak      (d2_ep_nak),
    .nak_irq_en  (d2_nak_irq_en),
    .full_speed  (d2_full_speed),
    .sof_rx      (d2_sof_rx),
    .sof_frame   (d2_sof_frame),
    .eop_rx      (d2_eop_rx),
    .to_irq_en   (d2_to_irq_en),
    .status_wr   (d2_status_wr),
    .count_wr    (d2_count_wr),
    .wr_data     (reg_wdata),
    .status_val  (d2_status),
    .frame_val   (d2_frame),
    .count_val   (d2_count),
    .timeout_evt (d2_timeout)
  );

  // Registered read; unmapped offsets read as zero
  always @(posedge mclk) begin
    if (!rst_b)
      reg_rdata <= 16'h0000;
    else if (reg_rd) begin
      case (reg_addr)
        `DEV1_STATUS_OFS: reg_rdata <= d1_status;
        `DEV1_FRAME_OFS:  reg_rdata <= d1_frame;
        `DEV1_COUNT_OFS:  reg_rdata <= d1_count;
        `DEV2_STATUS_OFS: reg_rdata <= d2_status;
        `DEV2_FRAME_OFS:  reg_rdata <= d2_frame;
        `DEV2_COUNT_OFS:  reg_rdata <= d2_count;
        default:          reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // usb_device_frame_sof_monitor

// *** host_link_model.sv ***
/* Host side of the link: SOF, EOP and endpoint events as one-cycle pulses.
   Assumes the device samples on the rising edge of mclk. */
`timescale 1ns/1ps
module host_link_model (
  input  wire         mclk,
  output logic        sof_rx,
  output logic [10:0] sof_frame,
  output logic        eop_rx,
  output logic [7:0]  ep_done,
  output logic [7:0]  ep_nak
);
  initial {sof_rx, sof_frame, eop_rx, ep_done, ep_nak} = 29'h0;
  // Frame lines show the inverse once the packet is over
  task sof(input logic [10:0] f, input logic e);
    @(negedge mclk) {sof_rx, eop_rx, sof_frame} = {~e, e, f};
    @(negedge mclk) {sof_rx, eop_rx, sof_frame} = {2'h0, ~f};
  endtask
  task ev(input logic [7:0] d, input logic [7:0] n);
    @(negedge mclk) {ep_done, ep_nak} = {d, n};
    @(negedge mclk) {ep_done, ep_nak} = 16'h0;
  endtask
endmodule // host_link_model

// *** sof_frame_monitor.sv ***
/* Assertions on the register port and the timeout pulses.
   Assumes it is bound onto the top module by port name. */
`timescale 1ns/1ps
module sof_frame_monitor (
  input wire        mclk,
  input wire        rst_b,
  input wire [15:0] reg_addr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        d1_sof_rx,
  input wire        d1_eop_rx,
  input wire        d1_timeout,
  input wire        d2_sof_rx,
  input wire        d2_timeout
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_d1_pulse_once: assert property (d1_timeout |=> !d1_timeout)
    else $error("d1 timeout longer than one cycle");
  a_d2_pulse_once: assert property (d2_timeout |=> !d2_timeout)
    else $error("d2 timeout longer than one cycle");
  a_d1_sof_reload: assert property (d1_sof_rx |=> !d1_timeout)
    else $error("d1 timeout right after SOF");
  a_d1_eop_reload: assert property (d1_eop_rx |=> !d1_timeout)
    else $error("d1 timeout right after EOP");
  a_d2_sof_reload: assert property (d2_sof_rx |=> !d2_timeout)
    else $error("d2 timeout right after SOF");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 16'hc000 |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  a_frame_rsvd: assert property (reg_rd && reg_addr == 16'hc092 |=> !reg_rdata[11])
    else $error("frame reserved bit set");
  a_count_rsvd: assert property (reg_rd && reg_addr == 16'hc094 |=> reg_rdata[15:14] == 2'h0)
    else $error("count reserved bits set");
endmodule // sof_frame_monitor
bind usb_device_frame_sof_monitor sof_frame_monitor mon (.mclk, .rst_b, .reg_addr, .reg_rd, .reg_rdata,
  .d1_sof_rx, .d1_eop_rx, .d1_timeout, .d2_sof_rx, .d2_timeout);

// *** tb.sv ***
/* Self-checking bench for the frame and SOF monitor.
   Assumes the host link model and the checker are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, v); end end
module tb;
  logic        mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, fs = 1, to_en = 1;
  logic [15:0] reg_addr = 16'hc094, reg_wdata = 16'h0, a, b;
  logic [7:0]  nak_en = 8'h0;
  wire  [15:0] reg_rdata;
  wire  [10:0] f1, f2;
  wire  [7:0]  dn1, nk1, dn2, nk2;
  wire         s1, e1, s2, e2, t1, t2;
  int          mismatches = 0, total_checks = 0, i;
  always #20 mclk = ~mclk;
  host_link_model h1 (.mclk, .sof_rx(s1), .sof_frame(f1), .eop_rx(e1), .ep_done(dn1), .ep_nak(nk1));
  host_link_model h2 (.mclk, .sof_rx(s2), .sof_frame(f2), .eop_rx(e2), .ep_done(dn2), .ep_nak(nk2));
  usb_device_frame_sof_monitor dut (.mclk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .d1_ep_done(dn1), .d1_ep_nak(nk1), .d1_nak_irq_en(nak_en), .d1_full_speed(fs), .d1_sof_rx(s1),
    .d1_sof_frame(f1), .d1_eop_rx(e1), .d1_to_irq_en(to_en), .d1_timeout(t1), .d2_ep_done(dn2),
    .d2_ep_nak(nk2), .d2_nak_irq_en(nak_en), .d2_full_speed(fs), .d2_sof_rx(s2), .d2_sof_frame(f2),
    .d2_eop_rx(e2), .d2_to_irq_en(to_en), .d2_timeout(t2));
  task wr(input logic [15:0] ad, input logic [15:0] d);
    @(negedge mclk) {reg_addr, reg_wdata, reg_wr} = {ad, d, 1'h1};
    @(negedge mclk) reg_wr = 0;
  endtask
  // An empty name only captures the word into a
  task rd(input string n, input logic [15:0] ad, input logic [15:0] e);
    @(negedge mclk) {reg_addr, reg_rd} = {ad, 1'h1};
    @(negedge mclk) reg_rd = 0;
    a = reg_rdata;
    if (n != "") `CHK(n, e, a)
  endtask
  task wto(input int k, input logic s);
    repeat (k) begin
      for (i = 0; i < 100 && (s ? t2 : t1) !== 1'h1; i++) @(negedge mclk);
      `CHK(s ? "d2_timeout" : "d1_timeout", 1'h1, s ? t2 : t1)
      @(negedge mclk);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (10) @(negedge mclk);
    {rst_b, reg_rd} = 2'h3;
    @(negedge mclk) reg_rd = 0;
    `CHK("count1", 16'h2ee0, reg_rdata)
    rd("frame1", 16'hc092, 16'h0000);
    rd("frame2", 16'hc0b2, 16'h0000);
    wr(16'hc092, 16'hffff);
    rd("frame_ro", 16'hc092, 16'h0000);
    rd("unmapped", 16'hc000, 16'h0000);
    h1.ev(8'h81, 8'h00);
    rd("done_flags", 16'hc090, 16'h0081);
    wr(16'hc090, 16'h0001);
    rd("clear_one", 16'hc090, 16'h0080);
    nak_en = 8'h02;
    h1.ev(8'h00, 8'h06);
    rd("nak_flags", 16'hc090, 16'h0082);
    wr(16'hc090, 16'h00ff);
    rd("clear_all", 16'hc090, 16'h0000);
    $display("test flags done");
    h1.sof(11'h5a5, 1'h0);
    rd("frame_cap", 16'hc092, 16'h05a5);
    wr(16'hc094, 16'h0003);
    wto(1, 1'h0);
    rd("first_to", 16'hc092, 16'h95a5);
    wto(8, 1'h0);
    rd("sat_to", 16'hc092, 16'hf5a5);
    wr(16'hc094, 16'h3fff);
    h1.sof(11'h123, 1'h0);
    rd("", 16'hc094, 16'h0);
    b = a;
    repeat (48) @(negedge mclk);
    rd("", 16'hc094, 16'h0);
    `CHK("count_step", 16'd24, b - a)
    rd("sof_clear", 16'hc092, 16'h0123);
    $display("test timeout done");
    @(negedge mclk) to_en = 0;
    wr(16'hc094, 16'h0003);
    wto(2, 1'h0);
    rd("to_gated", 16'hc092, 16'h8123);
    wr(16'hc094, 16'h3fff);
    repeat (48) @(negedge mclk);
    h1.sof(11'h000, 1'h1);
    rd("", 16'hc094, 16'h0);
    `CHK("eop_reload", 1'h1, a > 16'h3ffc)
    rd("eop_flag", 16'hc092, 16'h0123);
    fs = 0;
    h1.sof(11'h3c3, 1'h0);
    rd("ls_frame", 16'hc092, 16'h0123);
    fs = 1;
    $display("test gating done");
    h2.sof(11'h2aa, 1'h0);
    rd("frame_d2", 16'hc0b2, 16'h02aa);
    h2.ev(8'h10, 8'h00);
    rd("flags_d2", 16'hc0b0, 16'h0010);
    to_en = 1;
    wr(16'hc0b4, 16'h0003);
    wto(1, 1'h1);
    rd("to_d2", 16'hc0b2, 16'h92aa);
    $display("test second engine done");
    finish_test;
  end
endmodule // tb
